// File: txbuf_defines.svh
`ifndef TXBUF_DEFINES_SVH
`define TXBUF_DEFINES_SVH
`define ADDR_SINGLE_FRAME    8'h34
`define ADDR_TWO_FRAME_EXT   8'h38
`define ADDR_CTRL            8'h00
`define ADDR_STATUS          8'h04
`define ADDR_IF              8'h08
`define ADDR_IEN             8'h0c
`define SINGLE_DATA_MSB      7
`define LO_DATA_LSB          0
`define HI_DATA_LSB          16
`define LO_FLAG_LSB          11
`define HI_FLAG_LSB          27
`define IF_TRANSMIT_OVERFLOW_FLAG_BIT          0
`define IF_DONE_BIT          1
`define IF_W                 2
`define CTRL_TRANSMITTER_ENABLE_BIT        0
`define CTRL_TRI_BIT         1
`define CTRL_RXBLK_BIT       2
`define CTRL_RXEN_BIT        3
`define CTRL_W               4
`define CTRL_RESET           4'h4
`define FRAME_DATA_W         9
`define FLAG_W               5
`define HALF_W               16
`endif

// File: txbuf_pkg.sv
package txbuf_pkg;
    // flags order from msb: rx enable, tx disable, break, tristate, unblock
    typedef struct packed {
        logic       rx_enable_after;
        logic       tx_disable_after;
        logic       send_as_break;
        logic       tristate_after;
        logic       unblock_rx_after;
        logic [8:0] data;
    } frame_t;
    typedef enum logic [1:0] {IDLE, SEND} tx_state_t;
endpackage : txbuf_pkg

// File: frame_mem.sv
`timescale 1ns/1ps
`default_nettype none
module frame_mem #(
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic              clk_in,
    input  wire logic              wr_en_in,
    input  wire logic [AW-1:0]     wr_addr_in,
    input  wire txbuf_pkg::frame_t wr_data_in,
    input  wire logic [AW-1:0]     rd_addr_in,
    output var  txbuf_pkg::frame_t rd_data_out
);
    txbuf_pkg::frame_t mem_r [DEPTH];
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_r[rd_addr_in];
    end
endmodule : frame_mem
`default_nettype wire

// File: usart_tx_buffer_write_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "txbuf_defines.svh"
// Function
// - single write queues low byte frame
// - single write clears ninth bit, flags
// - extended write queues two flagged frames
// - lower field frame queued first
// - rx enable set after flagged frame
// - tx enable cleared after flagged frame
// - flagged frame sent as break
// - tristate set after flagged frame
// - receive block cleared after flagged frame
// - write when full sets overflow, keeps data
module usart_tx_buffer_write_port #(
    parameter int DEPTH = 4,
    parameter int AW    = 2,
    parameter int FRAME_CYCLES = 10
) (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    output logic             irq_out,
    output logic             tx_valid_out,
    output logic      [8:0]  tx_data_out,
    output logic             tx_break_out,
    output logic             transmitter_enable_out,
    output logic             transmit_output_tristate_out,
    output logic             receive_block_out,
    output logic             receiver_enable_out
);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

    function automatic txbuf_pkg::frame_t unpack(input logic [`HALF_W-1:0] h);
        txbuf_pkg::frame_t f;
        f = '0;
        f.data             = h[`LO_DATA_LSB +: `FRAME_DATA_W];
        {f.rx_enable_after, f.tx_disable_after, f.send_as_break, f.tristate_after,
         f.unblock_rx_after} = h[`LO_FLAG_LSB +: `FLAG_W];
        return f;
    endfunction : unpack

    // room check shared by the enqueue path and the AST_KEEP check; AST_OVF uses is_full instead
    function automatic logic fits(input logic [AW:0] used, input logic two);
        logic [AW+1:0] need;
        need = {1'b0, used} + (two ? (AW+2)'(2) : (AW+2)'(1));
        return (need <= {1'b0, DEPTH_C});
    endfunction : fits

    function automatic logic is_full(input logic [AW:0] used);
        return (used >= DEPTH_C);
    endfunction : is_full

    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          pend_r, pend_nxt;
    txbuf_pkg::frame_t pend_f_r, pend_f_nxt;
    txbuf_pkg::frame_t cur_r, cur_nxt, mem_wd, mem_rd;
    logic          mem_we;
    txbuf_pkg::tx_state_t st_r, st_nxt;
    logic [15:0]   tick_r, tick_nxt;
    logic          ld_r, ld_nxt;
    logic [`IF_W-1:0] if_r, if_nxt, ien_r, ien_nxt;
    logic [3:0]    ctrl_r, ctrl_nxt;
    logic [31:0]   rdata_nxt;
    logic          irq_nxt, done;
    logic [8:0]    txd_nxt;
    logic          txv_nxt, txb_nxt;
    logic [15:0]   len_r, len_nxt;

    frame_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk_in      (clk_in),
        .wr_en_in    (mem_we),
        .wr_addr_in  (wp_r),
        .wr_data_in  (mem_wd),
        .rd_addr_in  (rp_r),
        .rd_data_out (mem_rd)
    );

    wire logic wr_single = wr_in && addr_in == `ADDR_SINGLE_FRAME;
    wire logic wr_double = wr_in && addr_in == `ADDR_TWO_FRAME_EXT;

    always_comb begin
        wp_nxt     = wp_r;
        rp_nxt     = rp_r;
        cnt_nxt    = cnt_r;
        pend_nxt   = pend_r;
        pend_f_nxt = pend_f_r;
        cur_nxt    = cur_r;
        st_nxt     = st_r;
        tick_nxt   = tick_r;
        ld_nxt     = 1'b0;
        mem_we     = 1'b0;
        mem_wd     = '0;
        if_nxt     = if_r;
        ien_nxt    = ien_r;
        ctrl_nxt   = ctrl_r;
        done       = 1'b0;
        // engine: take frame, shift FRAME_CYCLES, then apply its actions
        case (st_r)
            txbuf_pkg::IDLE: begin
                if (cnt_r != '0 && ctrl_r[`CTRL_TRANSMITTER_ENABLE_BIT] && !ld_r) begin
                    ld_nxt = 1'b1;
                    rp_nxt = rp_r + AW'(1);
                end
                if (ld_r) begin
                    cur_nxt  = mem_rd;
                    st_nxt   = txbuf_pkg::SEND;
                    tick_nxt = 16'(FRAME_CYCLES - 1);
                end
            end
            txbuf_pkg::SEND: begin
                if (tick_r == '0) begin
                    done   = 1'b1;
                    st_nxt = txbuf_pkg::IDLE;
                    if (cur_r.rx_enable_after)  ctrl_nxt[`CTRL_RXEN_BIT]  = 1'b1;
                    if (cur_r.tx_disable_after) begin
                        ctrl_nxt[`CTRL_TRANSMITTER_ENABLE_BIT] = 1'b0;
                        ctrl_nxt[`CTRL_TRI_BIT]  = 1'b1;
                    end
                    if (cur_r.tristate_after)   ctrl_nxt[`CTRL_TRI_BIT]   = 1'b1;
                    if (cur_r.unblock_rx_after) ctrl_nxt[`CTRL_RXBLK_BIT] = 1'b0;
                end else begin
                    tick_nxt = tick_r - 16'h0001;
                end
            end
            default: st_nxt = txbuf_pkg::IDLE;
        endcase
        // software control write, hardware completion takes priority
        if (wr_in && addr_in == `ADDR_CTRL && !done) ctrl_nxt = wdata_in[`CTRL_W-1:0];
        if (wr_in && addr_in == `ADDR_IEN) ien_nxt = wdata_in[`IF_W-1:0];
        if (wr_in && addr_in == `ADDR_IF) if_nxt = if_nxt & ~wdata_in[`IF_W-1:0];
        // enqueue: upper frame of a double write waits one cycle
        if (pend_r) begin
            mem_we   = 1'b1;
            mem_wd   = pend_f_r;
            pend_nxt = 1'b0;
        end else if (wr_single || wr_double) begin
            if (!fits(cnt_r, wr_double)) begin
                if_nxt[`IF_TRANSMIT_OVERFLOW_FLAG_BIT] = 1'b1;
            end else begin
                mem_we = 1'b1;
                if (wr_single) begin
                    mem_wd = '0;
                    mem_wd.data = {1'b0, wdata_in[`SINGLE_DATA_MSB:0]};
                end else begin
                    mem_wd     = unpack(wdata_in[`LO_DATA_LSB +: `HALF_W]);
                    pend_nxt   = 1'b1;
                    pend_f_nxt = unpack(wdata_in[`HI_DATA_LSB +: `HALF_W]);
                end
            end
        end
        if (mem_we) wp_nxt = wp_r + AW'(1);
        cnt_nxt = cnt_r + (mem_we ? (AW+1)'(1) : '0) - (ld_nxt ? (AW+1)'(1) : '0);
        if (done) if_nxt[`IF_DONE_BIT] = 1'b1;
    end

    always_comb begin
        rdata_nxt = '0;
        if (rd_in) begin
            case (addr_in)
                `ADDR_CTRL:   rdata_nxt = {28'h0, ctrl_r};
                `ADDR_STATUS: rdata_nxt = {29'h0, st_r == txbuf_pkg::SEND, cnt_r != '0, is_full(cnt_r)};
                `ADDR_IF:     rdata_nxt = {30'h0, if_r};
                `ADDR_IEN:    rdata_nxt = {30'h0, ien_r};
                default:      rdata_nxt = '0;
            endcase
        end
        irq_nxt = |(if_nxt & ien_nxt);
        txv_nxt = st_nxt == txbuf_pkg::SEND;
        txd_nxt = cur_nxt.data;
        txb_nxt = cur_nxt.send_as_break;
    end

    // buffer pointers, fill count and held upper frame
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wp_r     <= '0;
            rp_r     <= '0;
            cnt_r    <= '0;
            pend_r   <= 1'b0;
            pend_f_r <= '0;
        end else begin
            wp_r     <= wp_nxt;
            rp_r     <= rp_nxt;
            cnt_r    <= cnt_nxt;
            pend_r   <= pend_nxt;
            pend_f_r <= pend_f_nxt;
        end
    end

    // frame engine
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cur_r  <= '0;
            st_r   <= txbuf_pkg::IDLE;
            tick_r <= '0;
            ld_r   <= 1'b0;
        end else begin
            cur_r  <= cur_nxt;
            st_r   <= st_nxt;
            tick_r <= tick_nxt;
            ld_r   <= ld_nxt;
        end
    end

    // software registers and registered outputs
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            if_r         <= '0;
            ien_r        <= '0;
            ctrl_r       <= `CTRL_RESET;
            rdata_out    <= '0;
            irq_out      <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_data_out  <= '0;
            tx_break_out <= 1'b0;
        end else begin
            if_r         <= if_nxt;
            ien_r        <= ien_nxt;
            ctrl_r       <= ctrl_nxt;
            rdata_out    <= rdata_nxt;
            irq_out      <= irq_nxt;
            tx_valid_out <= txv_nxt;
            tx_data_out  <= txd_nxt;
            tx_break_out <= txb_nxt;
        end
    end

    // shift-time counter read only by the assertions
    always_comb begin
        len_nxt = tx_valid_out ? len_r + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            len_r <= '0;
        end else begin
            len_r <= len_nxt;
        end
    end

    assign transmitter_enable_out       = ctrl_r[`CTRL_TRANSMITTER_ENABLE_BIT];
    assign transmit_output_tristate_out = ctrl_r[`CTRL_TRI_BIT];
    assign receive_block_out            = ctrl_r[`CTRL_RXBLK_BIT];
    assign receiver_enable_out          = ctrl_r[`CTRL_RXEN_BIT];

    AST_RXEN: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        done && cur_r.rx_enable_after |=> receiver_enable_out)
        else $error("rx enable missed");

    AST_TXDIS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        done && cur_r.tx_disable_after |=> !transmitter_enable_out && transmit_output_tristate_out)
        else $error("tx disable missed");

    AST_TRI: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        done && cur_r.tristate_after |=> transmit_output_tristate_out)
        else $error("tristate missed");

    AST_UNBLK: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        done && cur_r.unblock_rx_after |=> !receive_block_out)
        else $error("unblock missed");

    AST_OVF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_single && !pend_r && !ld_nxt && is_full(cnt_r) |=> if_r[`IF_TRANSMIT_OVERFLOW_FLAG_BIT] && $stable(cnt_r))
        else $error("overflow not flagged");

    AST_KEEP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (wr_single || wr_double) && !pend_r && !fits(cnt_r, wr_double) |-> !mem_we)
        else $error("refused frame stored");

    AST_SDATA: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_single && mem_we |-> mem_wd.data[`SINGLE_DATA_MSB:0] == wdata_in[`SINGLE_DATA_MSB:0])
        else $error("single frame data wrong");

    AST_SINGLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_single && mem_we |-> mem_wd[13:8] == 6'h00)
        else $error("single frame flags not zero");

    AST_DLOW: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_double && mem_we && !pend_r |->
            mem_wd == {wdata_in[`LO_FLAG_LSB +: `FLAG_W], wdata_in[`LO_DATA_LSB +: `FRAME_DATA_W]})
        else $error("lower frame fields wrong");

    AST_DHIGH: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_double && mem_we && !pend_r |->
            pend_f_nxt == {wdata_in[`HI_FLAG_LSB +: `FLAG_W], wdata_in[`HI_DATA_LSB +: `FRAME_DATA_W]})
        else $error("upper frame fields wrong");

    AST_ORDER: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wr_double && mem_we && !pend_r |=> pend_r && mem_we)
        else $error("upper frame not queued next");

    AST_BREAK: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        tx_valid_out |-> tx_break_out == cur_r.send_as_break)
        else $error("break flag mismatch");

    AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        !done && !(wr_in && addr_in == `ADDR_CTRL) |=> $stable(ctrl_r))
        else $error("control changed outside frame completion");

    AST_FRAME_LEN: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        $fell(tx_valid_out) |-> len_r == 16'(FRAME_CYCLES))
        else $error("frame ended at wrong time");

    COV_DOUBLE: cover property (@(posedge clk_in) disable iff (!rst_b_in) wr_double && mem_we);
    COV_OVF: cover property (@(posedge clk_in) disable iff (!rst_b_in) if_nxt[`IF_TRANSMIT_OVERFLOW_FLAG_BIT] && !if_r[`IF_TRANSMIT_OVERFLOW_FLAG_BIT]);
    COV_DONE: cover property (@(posedge clk_in) disable iff (!rst_b_in) done && cur_r.tx_disable_after);
    COV_BREAK: cover property (@(posedge clk_in) disable iff (!rst_b_in) tx_valid_out && tx_break_out);
endmodule : usart_tx_buffer_write_port
`default_nettype wire

// File: remote_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module remote_peer_model (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       line_valid_in,
    input  wire logic [8:0] line_data_in,
    input  wire logic       line_break_in,
    output logic            got_out,
    output logic      [8:0] got_data_out,
    output logic            got_ferr_out
);
    logic valid_d_r;
    // one pulse per finished frame, holding what was seen on the line
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            valid_d_r    <= 1'b0;
            got_out      <= 1'b0;
            got_data_out <= 9'h000;
            got_ferr_out <= 1'b0;
        end else begin
            valid_d_r <= line_valid_in;
            got_out   <= valid_d_r && !line_valid_in;
            if (line_valid_in) begin
                got_data_out <= line_data_in;
                got_ferr_out <= line_break_in;
            end
        end
    end
endmodule : remote_peer_model
`default_nettype wire

// File: test_usart_tx_buffer_write_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_usart_tx_buffer_write_port;
    logic              clk_in   = 1'b0;
    logic              rst_b_in = 1'b0;
    logic              wr_in    = 1'b0;
    logic              rd_in    = 1'b0;
    logic [7:0]        addr_in  = 8'h00;
    logic [7:0]        lfsr     = 8'h5a;
    logic [7:0]        d8;
    logic [31:0]       wdata_in = 32'h00000000;
    logic [31:0]       rdata_out;
    logic              irq_out, tx_valid_out, tx_break_out, got, ferr, transmitter_enable, tri_o, rxblk, rxen;
    logic [8:0]        tx_data_out, got_data;
    logic [3:0]        exp_ctrl = 4'h4;
    int                fails = 0, checks_done = 0, cycles = 0;
    txbuf_pkg::frame_t cur;
    txbuf_pkg::frame_t exp_q[$];

    usart_tx_buffer_write_port #(.DEPTH(4), .AW(2), .FRAME_CYCLES(10)) usart_tx_buffer_write_port_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .tx_valid_out(tx_valid_out),
        .tx_data_out(tx_data_out), .tx_break_out(tx_break_out), .transmitter_enable_out(transmitter_enable),
        .transmit_output_tristate_out(tri_o), .receive_block_out(rxblk), .receiver_enable_out(rxen));
    remote_peer_model remote_peer_model_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .line_valid_in(tx_valid_out), .line_data_in(tx_data_out),
        .line_break_in(tx_break_out), .got_out(got), .got_data_out(got_data), .got_ferr_out(ferr));

    always #12.5 clk_in = ~clk_in;

    task automatic final_report();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction : rnd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        @(posedge clk_in);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, e);
    endtask : rd

    task automatic dbl(input logic [4:0] f0, input logic [4:0] f1);
        logic [8:0] d0, d1;
        d0 = {1'b1, rnd()};
        d1 = {1'b0, rnd()};
        exp_q.push_back({f0, d0});
        exp_q.push_back({f1, d1});
        wr(8'h38, {f1, 2'b00, d1, f0, 2'b00, d0});
    endtask : dbl

    task automatic idle();
        while (exp_q.size() != 0) @(posedge clk_in);
        repeat (4) @(posedge clk_in);
    endtask : idle

    always @(negedge clk_in) begin
        if (got) begin
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else begin
                cur = exp_q.pop_front();
                if (cur.rx_enable_after) exp_ctrl[3] = 1'b1;
                if (cur.unblock_rx_after) exp_ctrl[2] = 1'b0;
                if (cur.tristate_after || cur.tx_disable_after) exp_ctrl[1] = 1'b1;
                if (cur.tx_disable_after) exp_ctrl[0] = 1'b0;
                chk({ferr, got_data}, {cur.send_as_break, cur.data});
                chk({rxen, rxblk, tri_o, transmitter_enable}, exp_ctrl);
            end
        end
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        #1 chk({rxen, rxblk, tri_o, transmitter_enable}, 4'h4);
        rd(8'h00, 32'h4);
        wr(8'h00, 32'h5);
        exp_ctrl = 4'h5;
        d8 = rnd();
        exp_q.push_back({6'h00, d8});
        wr(8'h34, {24'h0, d8});
        idle();
        dbl(5'b00001, 5'b10000);
        wait (tx_valid_out);
        #1 chk({rxen, rxblk, tri_o, transmitter_enable}, 4'h5);
        idle();
        dbl(5'b00110, 5'b01000);
        idle();
        for (int i = 0; i < 5; i++) begin
            d8 = rnd();
            if (i < 4) exp_q.push_back({6'h00, d8});
            wr(8'h34, {24'h0, d8});
        end
        rd(8'h08, 32'h3);
        rd(8'h04, 32'h3);
        chk(irq_out, 1'b0);
        wr(8'h0c, 32'h1);
        #1 chk(irq_out, 1'b1);
        wr(8'h08, 32'h3);
        #1 chk(irq_out, 1'b0);
        rd(8'h08, 32'h0);
        rd(8'hf0, 32'h0);
        wr(8'h00, 32'h1);
        exp_ctrl = 4'h1;
        idle();
        repeat (20) @(posedge clk_in);
        rd(8'h04, 32'h0);
        chk(exp_q.size(), 32'h0);
        final_report();
    end
endmodule : test_usart_tx_buffer_write_port
`default_nettype wire
